// [hw/sac_pkg.sv]
// Constants shared by the converter sequencing and readout logic.
// Assumes a single 10 MHz clock; all times are turned into cycles here.
package sac_pkg;

  localparam int CLK_NS = 100;

  // Minimum times round up, maximum times round down, never below one cycle
  function automatic int cyc_up(input int ns);
    cyc_up = (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up

  function automatic int cyc_dn(input int ns);
    cyc_dn = (ns / CLK_NS > 0) ? ns / CLK_NS : 1;
  endfunction : cyc_dn

  // Conversion time maximum per mode
  localparam int CONV_FAST_NS = 750;
  localparam int CONV_NORM_NS = 1000;
  localparam int CONV_PWR_NS = 1250;
  localparam logic [3:0] CONV_FAST_CYC = 4'(cyc_dn(CONV_FAST_NS));
  localparam logic [3:0] CONV_NORM_CYC = 4'(cyc_dn(CONV_NORM_NS));
  localparam logic [3:0] CONV_PWR_CYC = 4'(cyc_dn(CONV_PWR_NS));

  // Start spacing minimum per mode, fast mode maximum gap
  localparam int SPACE_FAST_NS = 1750;
  localparam int SPACE_NORM_NS = 2000;
  localparam int SPACE_PWR_NS = 2250;
  localparam logic [4:0] SPACE_FAST_CYC = 5'(cyc_up(SPACE_FAST_NS));
  localparam logic [4:0] SPACE_NORM_CYC = 5'(cyc_up(SPACE_NORM_NS));
  localparam logic [4:0] SPACE_PWR_CYC = 5'(cyc_up(SPACE_PWR_NS));
  localparam int MAX_GAP_NS = 1000000;
  localparam int MAX_GAP_CYC = cyc_dn(MAX_GAP_NS);

  // Master clock half periods from the minimum period per divider code
  localparam int SCLK_MIN_NS [4] = '{25, 50, 100, 200};
  localparam logic [2:0] HALF_CYC [4] = '{3'(cyc_up(SCLK_MIN_NS[0] / 2)),
    3'(cyc_up(SCLK_MIN_NS[1] / 2)), 3'(cyc_up(SCLK_MIN_NS[2] / 2)),
    3'(cyc_up(SCLK_MIN_NS[3] / 2))};
  // Sync lead before first edge and hold after last edge per code
  localparam int LEAD_NS [4] = '{4, 20, 20, 20};
  localparam int TAIL_NS [4] = '{3, 60, 140, 300};
  localparam logic [2:0] LEAD_CYC [4] = '{3'(cyc_up(LEAD_NS[0])), 3'(cyc_up(LEAD_NS[1])),
    3'(cyc_up(LEAD_NS[2])), 3'(cyc_up(LEAD_NS[3]))};
  localparam logic [2:0] TAIL_CYC [4] = '{3'(cyc_up(TAIL_NS[0])), 3'(cyc_up(TAIL_NS[1])),
    3'(cyc_up(TAIL_NS[2])), 3'(cyc_up(TAIL_NS[3]))};

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control fields
  localparam int CTRL_FAST = 0;
  localparam int CTRL_PWR = 1;
  localparam int CTRL_SERIAL = 2;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_RAC = 4;
  localparam int CTRL_DIV_LO = 5;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Interrupt status bits
  localparam int IRQ_CONV = 0;
  localparam int IRQ_XFER = 1;
  localparam int IRQ_SOON = 2;
  localparam int IRQ_STALE = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  typedef enum logic [1:0] {
    SAC_C_IDLE = 2'b00,
    SAC_C_RUN = 2'b01,
    SAC_C_WAIT = 2'b11,
    SAC_C_DROP = 2'b10
  } sac_conv_t;

  typedef enum logic [1:0] {
    SAC_S_IDLE = 2'b00,
    SAC_S_LEAD = 2'b01,
    SAC_S_SHIFT = 2'b11,
    SAC_S_TAIL = 2'b10
  } sac_ser_t;

endpackage : sac_pkg

// [hw/sac_timer.sv]
// Loadable down counter with a one-cycle expiry pulse.
// Assumes the caller holds ce_i high for counting.
`timescale 1ns/1ps
`default_nettype none
module sac_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  // Status
  output logic done_o,
  output logic expire_o
);

  logic [W-1:0] cnt_ff;
  logic exp_ff;
  wire logic [W-1:0] nxt_cnt = load_i ? value_i : (done_o ? cnt_ff : cnt_ff - 1'b1);
  wire logic nxt_exp = !load_i && (cnt_ff == W'(1));

  assign done_o = (cnt_ff == '0);
  assign expire_o = exp_ff;

  // Count down to zero and rest there
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

endmodule : sac_timer
`default_nettype wire

// [hw/sac_shifter.sv]
// Result shift register, most significant bit first, with chain input.
// Assumes load and shift never arrive together; load wins if they do.
`timescale 1ns/1ps
`default_nettype none
module sac_shifter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] data_i,
  input wire logic shift_i,
  input wire logic fill_i,
  // Serial bit
  output logic bit_o
);

  logic [W-1:0] sr_ff;
  wire logic [W-1:0] nxt_sr = load_i ? data_i : (shift_i ? {sr_ff[W-2:0], fill_i} : sr_ff);

  assign bit_o = sr_ff[W-1];

  // Load a fresh result or move one place
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sr_ff <= '0;
    end else if (ce_i) begin
      sr_ff <= nxt_sr;
    end
  end

endmodule : sac_shifter
`default_nettype wire

// [hw/sac_top.sv]
// Conversion sequencer and result readout of a 16-bit SAR converter.
// Assumes synchronous pins, an APB master and a core that delivers
// its result on result_i while the conversion is running.
`timescale 1ns/1ps
`default_nettype none
module sac_top #(
  parameter int RES_W = 16,
  parameter int MAX_GAP = sac_pkg::MAX_GAP_CYC
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Conversion control and core result
  input wire logic convert_start_n_i,
  input wire logic [RES_W-1:0] result_i,
  output logic busy_o,
  // Parallel port
  input wire logic cs_n_i,
  output logic [RES_W-1:0] data_o,
  output logic data_oe_o,
  // Serial port
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  output logic sync_o,
  output logic sync_oe_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // Interrupt
  output logic irq_o
);

  // Registers
  logic [6:0] ctrl_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic start_n_ff;
  logic sclk_in_ff;
  logic busy_ff;
  logic [RES_W-1:0] data_ff;
  logic data_oe_ff;
  logic sync_ff;
  logic sclk_ff;
  logic sdo_ff;
  logic ser_oe_ff;
  logic mst_oe_ff;
  logic [4:0] bit_cnt_ff;
  logic fast_seen_ff;
  sac_pkg::sac_conv_t conv_ff;
  sac_pkg::sac_conv_t nxt_conv;
  sac_pkg::sac_ser_t ser_ff;
  sac_pkg::sac_ser_t nxt_ser;

  // Mode decode from control bits
  wire logic mode_fast = ctrl_ff[sac_pkg::CTRL_FAST] && !ctrl_ff[sac_pkg::CTRL_PWR];
  wire logic mode_pwr = ctrl_ff[sac_pkg::CTRL_PWR] && !ctrl_ff[sac_pkg::CTRL_FAST];
  wire logic port_serial = ctrl_ff[sac_pkg::CTRL_SERIAL];
  wire logic ser_master = port_serial && ctrl_ff[sac_pkg::CTRL_MASTER];
  wire logic ser_slave = port_serial && !ctrl_ff[sac_pkg::CTRL_MASTER];
  wire logic rac = ser_master && ctrl_ff[sac_pkg::CTRL_RAC];
  wire logic rdc = ser_master && !ctrl_ff[sac_pkg::CTRL_RAC];
  wire logic [1:0] div_code = ctrl_ff[sac_pkg::CTRL_DIV_LO +: 2];
  // Read-during-convert always runs at the fastest divider timing
  wire logic [1:0] eff_div = rac ? div_code : 2'b00;

  // Mode dependent cycle counts
  wire logic [3:0] conv_cyc = mode_fast ? sac_pkg::CONV_FAST_CYC :
    (mode_pwr ? sac_pkg::CONV_PWR_CYC : sac_pkg::CONV_NORM_CYC);
  wire logic [4:0] space_cyc = mode_fast ? sac_pkg::SPACE_FAST_CYC :
    (mode_pwr ? sac_pkg::SPACE_PWR_CYC : sac_pkg::SPACE_NORM_CYC);
  wire logic [2:0] half_cyc = sac_pkg::HALF_CYC[eff_div];
  wire logic [2:0] lead_cyc = sac_pkg::LEAD_CYC[eff_div];
  wire logic [2:0] tail_cyc = sac_pkg::TAIL_CYC[eff_div];

  // Start edge and spacing check
  wire logic start_edge = start_n_ff && !convert_start_n_i;
  wire logic space_done;
  wire logic gap_expire;
  wire logic too_soon = start_edge && !space_done;
  wire logic start_ok = start_edge && space_done && conv_ff == sac_pkg::SAC_C_IDLE;
  wire logic start_lost = start_edge && space_done && conv_ff != sac_pkg::SAC_C_IDLE;

  // Conversion timer: result posted one cycle before busy falls outside RAC
  wire logic conv_done;
  wire logic conv_expire;
  wire logic post_result = conv_ff == sac_pkg::SAC_C_RUN && conv_done;

  // Serial timing timer shared by lead, half period and tail
  wire logic ser_tmr_done;
  wire logic ser_start = (rac && post_result) || (rdc && start_ok);
  wire logic last_fall = ser_ff == sac_pkg::SAC_S_SHIFT && ser_tmr_done && sclk_ff &&
    bit_cnt_ff == 5'(RES_W - 1);
  wire logic ser_end = ser_ff == sac_pkg::SAC_S_TAIL && ser_tmr_done;
  wire logic ser_load_tmr = ser_start ||
    (ser_ff != sac_pkg::SAC_S_IDLE && ser_tmr_done && !ser_end);
  wire logic [2:0] ser_tmr_val = ser_start ? lead_cyc : (last_fall ? tail_cyc : half_cyc);
  wire logic m_fall = ser_ff == sac_pkg::SAC_S_SHIFT && ser_tmr_done && sclk_ff;
  wire logic m_rise = (ser_ff == sac_pkg::SAC_S_SHIFT || ser_ff == sac_pkg::SAC_S_LEAD) &&
    ser_tmr_done && !sclk_ff;

  // Slave clock edge; pin taken as synchronous
  wire logic s_rise = ser_slave && !cs_n_i && sclk_i && !sclk_in_ff;
  wire logic sh_load = post_result && !rdc;
  wire logic sh_rdc_load = rdc && start_ok;
  wire logic sh_bit;

  sac_timer #(.W(5)) u_space (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(start_ok),
    .value_i(space_cyc - 5'd1),
    .done_o(space_done),
    .expire_o()
  );

  sac_timer #(.W(14)) u_gap (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(start_ok),
    .value_i(14'(MAX_GAP)),
    .done_o(),
    .expire_o(gap_expire)
  );

  sac_timer #(.W(4)) u_conv (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(start_ok),
    .value_i(conv_cyc - 4'd2),
    .done_o(conv_done),
    .expire_o(conv_expire)
  );

  sac_timer #(.W(3)) u_ser (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(ser_load_tmr),
    .value_i(ser_tmr_val - 3'd1),
    .done_o(ser_tmr_done),
    .expire_o()
  );

  // RDC sends the previous result while the new one converts
  sac_shifter #(.W(RES_W)) u_shift (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .load_i(sh_load || sh_rdc_load),
    .data_i(sh_rdc_load ? data_ff : result_i),
    .shift_i(m_fall || s_rise),
    .fill_i(serial_data_in_i),
    .bit_o(sh_bit)
  );

  // Conversion sequencer
  always_comb begin
    nxt_conv = conv_ff;
    case (conv_ff)
      sac_pkg::SAC_C_IDLE: begin
        if (start_ok) begin
          nxt_conv = sac_pkg::SAC_C_RUN;
        end
      end
      sac_pkg::SAC_C_RUN: begin
        if (post_result) begin
          nxt_conv = rac ? sac_pkg::SAC_C_WAIT : sac_pkg::SAC_C_DROP;
        end
      end
      sac_pkg::SAC_C_WAIT: begin
        if (ser_end) begin
          nxt_conv = sac_pkg::SAC_C_DROP;
        end
      end
      sac_pkg::SAC_C_DROP: nxt_conv = sac_pkg::SAC_C_IDLE;
      default: nxt_conv = sac_pkg::SAC_C_IDLE;
    endcase
  end

  // Master serial sequencer
  always_comb begin
    nxt_ser = ser_ff;
    case (ser_ff)
      sac_pkg::SAC_S_IDLE: begin
        if (ser_start) begin
          nxt_ser = sac_pkg::SAC_S_LEAD;
        end
      end
      sac_pkg::SAC_S_LEAD: begin
        if (ser_tmr_done) begin
          nxt_ser = sac_pkg::SAC_S_SHIFT;
        end
      end
      sac_pkg::SAC_S_SHIFT: begin
        if (last_fall) begin
          nxt_ser = sac_pkg::SAC_S_TAIL;
        end
      end
      sac_pkg::SAC_S_TAIL: begin
        if (ser_tmr_done) begin
          nxt_ser = sac_pkg::SAC_S_IDLE;
        end
      end
      default: nxt_ser = sac_pkg::SAC_S_IDLE;
    endcase
  end

  // Busy rises on the start edge, falls at the end of DROP
  wire logic nxt_busy = start_ok || (busy_ff && nxt_conv != sac_pkg::SAC_C_IDLE);
  // Busy would fall one cycle later in RAC, so one cycle of margin is kept
  wire logic nxt_sync = (ser_start || ser_ff != sac_pkg::SAC_S_IDLE) && !ser_end;
  wire logic nxt_sclk = m_rise ? 1'b1 : (m_fall ? 1'b0 : sclk_ff);
  wire logic [4:0] nxt_bit_cnt = ser_start ? 5'd0 : (m_fall ? bit_cnt_ff + 5'd1 : bit_cnt_ff);
  // Serial pins float on the clock after select rises
  wire logic nxt_ser_oe = port_serial && !cs_n_i;
  wire logic nxt_mst_oe = ser_master && !cs_n_i;
  wire logic nxt_data_oe = !port_serial && !cs_n_i;

  // Conversion and port state
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      conv_ff <= sac_pkg::SAC_C_IDLE;
      ser_ff <= sac_pkg::SAC_S_IDLE;
      busy_ff <= 1'b0;
      start_n_ff <= 1'b1;
      sclk_in_ff <= 1'b0;
      data_ff <= '0;
      data_oe_ff <= 1'b0;
    end else if (ce_i) begin
      conv_ff <= nxt_conv;
      ser_ff <= nxt_ser;
      busy_ff <= nxt_busy;
      start_n_ff <= convert_start_n_i;
      sclk_in_ff <= sclk_i;
      data_oe_ff <= nxt_data_oe;
      if (post_result) begin
        data_ff <= result_i;
      end
    end
  end

  // Serial pin state
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sync_ff <= 1'b0;
      sclk_ff <= 1'b0;
      sdo_ff <= 1'b0;
      ser_oe_ff <= 1'b0;
      mst_oe_ff <= 1'b0;
      bit_cnt_ff <= 5'd0;
    end else if (ce_i) begin
      sync_ff <= nxt_sync;
      sclk_ff <= nxt_sclk;
      sdo_ff <= sh_bit;
      ser_oe_ff <= nxt_ser_oe;
      mst_oe_ff <= nxt_mst_oe;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // APB decode: no wait cycle, answer registered
  wire logic apb_setup = psel_i && !penable_i;
  wire logic apb_wr = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
  wire logic hit_ctrl = paddr_i == sac_pkg::OFS_CTRL;
  wire logic hit_stat = paddr_i == sac_pkg::OFS_STATUS;
  wire logic hit_res = paddr_i == sac_pkg::OFS_RESULT;
  wire logic hit_istat = paddr_i == sac_pkg::OFS_IRQ_STAT;
  wire logic hit_imask = paddr_i == sac_pkg::OFS_IRQ_MASK;
  wire logic hit_any = hit_ctrl || hit_stat || hit_res || hit_istat || hit_imask;
  wire logic [31:0] rd_mux =
    hit_ctrl ? {25'h0, ctrl_ff} :
    hit_stat ? {24'h0, ser_ff, conv_ff, mode_pwr, mode_fast, sync_ff, busy_ff} :
    hit_res ? {{(32 - RES_W){1'b0}}, data_ff} :
    hit_istat ? {28'h0, irq_stat_ff} :
    hit_imask ? {28'h0, irq_mask_ff} : 32'h0;

  // Events; the gap check only matters in fast mode
  wire logic stale = gap_expire && mode_fast && fast_seen_ff;
  wire logic [3:0] irq_set = {stale, too_soon || start_lost, ser_end, conv_expire};
  wire logic [3:0] irq_clr = (apb_wr && hit_istat) ? pwdata_i[3:0] : 4'h0;
  // Set beats a clear in the same cycle
  wire logic [3:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  wire logic nxt_irq = |(nxt_irq_stat & irq_mask_ff);

  // Register file and bus answer
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_ff <= sac_pkg::CTRL_RESET;
      irq_stat_ff <= sac_pkg::IRQ_RESET;
      irq_mask_ff <= sac_pkg::IRQ_RESET;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
      fast_seen_ff <= 1'b0;
    end else if (ce_i) begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !hit_any;
      if (apb_setup) begin
        prdata_ff <= rd_mux;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_ff <= pwdata_i[6:0];
      end
      if (apb_wr && hit_imask) begin
        irq_mask_ff <= pwdata_i[3:0];
      end
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
      fast_seen_ff <= start_ok ? 1'b1 : fast_seen_ff;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign busy_o = busy_ff;
  assign data_o = data_ff;
  assign data_oe_o = data_oe_ff;
  assign sync_o = sync_ff;
  assign sclk_o = sclk_ff;
  assign serial_data_out_o = sdo_ff;
  assign sync_oe_o = mst_oe_ff;
  assign sclk_oe_o = mst_oe_ff;
  assign serial_data_out_oe_o = ser_oe_ff;
  assign irq_o = irq_ff;

endmodule : sac_top
`default_nettype wire

// [verif/sac_top_sva.sv]
// Port assertions for the converter sequencer and readout.
// Assumes it is bound to sac_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sac_top_sva #(
  parameter int RES_W = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic convert_start_n_i,
  input wire logic cs_n_i,
  input wire logic busy_o,
  input wire logic [RES_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic sync_o,
  input wire logic sync_oe_o,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic serial_data_out_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Frame opening and busy release steps
  sequence s_lead;
    !sclk_o ##1 sclk_o;
  endsequence
  sequence s_busy_tail;
    busy_o ##[1:2] !busy_o;
  endsequence

  a_busy_cause: assert property ($rose(busy_o) |-> !$past(convert_start_n_i) || !$past(convert_start_n_i, 2))
    else $error("busy rose without a start edge");
  a_busy_bound: assert property ($rose(busy_o) |-> ##[1:60] !busy_o)
    else $error("busy held too long");
  a_data_settled: assert property ($fell(busy_o) |-> $stable(data_o))
    else $error("result changed as busy fell");
  a_par_oe_off: assert property (cs_n_i |=> !data_oe_o)
    else $error("parallel bus driven while deselected");
  a_ser_oe_off: assert property (cs_n_i |=> !sync_oe_o && !sclk_oe_o && !serial_data_out_oe_o)
    else $error("serial pins driven while deselected");
  a_sync_lead: assert property ($rose(sync_o) |-> s_lead)
    else $error("sync does not lead the first clock edge");
  a_sclk_framed: assert property (sclk_o |-> sync_o)
    else $error("serial clock outside a frame");
  a_sclk_half: assert property ($rose(sclk_o) |=> !sclk_o)
    else $error("serial clock high time wrong");
  a_sync_tail: assert property ($fell(sync_o) |-> !$past(sclk_o))
    else $error("sync dropped right after a clock edge");
  a_busy_drop: assert property ($fell(sync_o) && busy_o |-> s_busy_tail)
    else $error("busy late after sync fell");
  a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer in the access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held over two cycles");
endmodule : sac_top_sva
`default_nettype wire

// [verif/sac_host.sv]
// Host model that reads converter results over the serial port.
// Assumes everything is sampled on the shared system clock.
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  // Clock
  input wire logic clock_i,
  // Converter serial pins
  input wire logic sync_i,
  input wire logic sclk_i,
  input wire logic sdo_i,
  // Bench control and captured word
  input wire logic go_i,
  output logic sclk_o,
  output logic [15:0] word_o,
  output logic vld_o
);
  logic prev_sclk = 1'b0;
  logic prev_sync = 1'b0;

  // Slave frame on request, else capture master frames; clock idles low
  initial begin
    sclk_o = 1'b0;
    word_o = 16'h0;
    vld_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (go_i) begin
        for (int i = 0; i < 16; i++) begin
          word_o <= {word_o[14:0], sdo_i};
          sclk_o <= 1'b1;
          repeat (3) @(posedge clock_i);
          sclk_o <= 1'b0;
          repeat (3) @(posedge clock_i);
        end
        vld_o <= 1'b1;
      end else begin
        if (sync_i && sclk_i && !prev_sclk) word_o <= {word_o[14:0], sdo_i};
        vld_o <= prev_sync && !sync_i;
      end
      prev_sclk = sclk_i;
      prev_sync = sync_i;
    end
  end
endmodule : sac_host
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the converter sequencer and readout.
// Assumes the host model and the port checker of this folder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, seed = 32'h324d;
  logic pready_o, pslverr_o, busy_o, data_oe_o, sclk_i, sync_o, sync_oe_o, sclk_o, sclk_oe_o;
  logic convert_start_n_i = 1'b1, cs_n_i = 1'b0, go = 1'b0, sdo, sdo_oe, irq_o, word_vld;
  logic [15:0] result_i = 16'h0, data_o, word, last = 16'h0;
  logic [32:0] rd_q[$];
  logic [20:0] cv_q[$];
  logic [15:0] sr_q[$];
  // Busy width per mode equals the conversion time in whole cycles
  logic [4:0] wid [4] = '{5'(sac_pkg::CONV_NORM_CYC), 5'(sac_pkg::CONV_FAST_CYC),
    5'(sac_pkg::CONV_PWR_CYC), 5'(sac_pkg::CONV_NORM_CYC)};
  int miscompares = 0, num_checks = 0, cnt = 0;

  always #50 clock_i = ~clock_i;

  // Stale gap shortened to 50 cycles to keep the run short
  sac_top #(.RES_W(16), .MAX_GAP(50)) i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .convert_start_n_i(convert_start_n_i), .result_i(result_i), .busy_o(busy_o),
    .cs_n_i(cs_n_i), .data_o(data_o), .data_oe_o(data_oe_o), .sclk_i(sclk_i),
    .serial_data_in_i(1'b0), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe_o), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
    .irq_o(irq_o));
  // Released pins read low, released data reads inverted
  sac_host i_host (.clock_i(clock_i), .sync_i(sync_o && sync_oe_o),
    .sclk_i(sclk_o && sclk_oe_o), .sdo_i(sdo_oe ? sdo : ~sdo),
    .go_i(go), .sclk_o(sclk_i), .word_o(word), .vld_o(word_vld));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic start(input int gap);
    convert_start_n_i <= 1'b0;
    @(posedge clock_i);
    convert_start_n_i <= 1'b1;
    repeat (gap) @(posedge clock_i);
  endtask : start

  // ser: 1 expects the new result serially, 2 the previous one
  task automatic convert(input logic [4:0] w, input logic [1:0] ser, input int gap);
    if (ser == 2'd2) sr_q.push_back(last);
    seed = lfsr(seed);
    result_i <= seed[15:0];
    last = seed[15:0];
    if (ser == 2'd1) sr_q.push_back(last);
    if (w != 5'd0) cv_q.push_back({w, last});
    start(gap);
  endtask : convert

  task automatic conclude();
    // Notes never matched by a result count as mismatches
    miscompares += rd_q.size() + cv_q.size() + sr_q.size();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // Results are matched against the oldest note of their kind
  always @(posedge clock_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && rd_q.size() > 0)
      check({pslverr_o, prdata_o}, rd_q.pop_front());
    if (word_vld === 1'b1 && sr_q.size() > 0) begin
      check({17'h0, word}, {17'h0, sr_q.pop_front()});
    end
    if (busy_o === 1'b1) cnt++;
    else if (cnt > 0) begin
      if (cv_q.size() > 0) begin
        check({12'h0, 5'(cnt), data_o}, {12'h0, cv_q.pop_front()});
      end
      cnt = 0;
    end
  end

  // Watchdog well beyond the roughly 900 cycles of stimulus
  initial begin
    repeat (5000) @(posedge clock_i);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd(sac_pkg::OFS_CTRL, 33'h0);
    rd(sac_pkg::OFS_IRQ_MASK, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, sac_pkg::OFS_CTRL, 32'(m));
      convert(wid[m], 2'd0, 40);
    end
    cs_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check({32'h0, data_oe_o}, 33'h0);
    cs_n_i <= 1'b0;
    // Early start refused, interrupt raised, masked and cleared
    apb(1'b1, sac_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, sac_pkg::OFS_IRQ_MASK, 32'h4);
    convert(5'(sac_pkg::CONV_FAST_CYC), 2'd0, 1);
    apb(1'b1, sac_pkg::OFS_IRQ_STAT, 32'hf);
    repeat (4) @(posedge clock_i);
    start(3);
    check({32'h0, busy_o}, 33'h0);
    rd(sac_pkg::OFS_IRQ_STAT, 33'h5);
    check({32'h0, irq_o}, 33'h1);
    apb(1'b1, sac_pkg::OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clock_i);
    check({32'h0, irq_o}, 33'h0);
    repeat (60) @(posedge clock_i);
    rd(sac_pkg::OFS_IRQ_STAT, 33'h9);
    check({32'h0, irq_o}, 33'h0);
    // Master read after convert for every divider code
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, sac_pkg::OFS_CTRL, 32'h1c | 32'(d << 5));
      convert(5'd0, 2'd1, 70);
    end
    apb(1'b1, sac_pkg::OFS_CTRL, 32'hc);
    // Master pins driven with select low, released with it high
    check({30'h0, sync_oe_o, sclk_oe_o, sdo_oe}, 33'h7);
    cs_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check({30'h0, sync_oe_o, sclk_oe_o, sdo_oe}, 33'h0);
    cs_n_i <= 1'b0;
    convert(5'd0, 2'd2, 70);
    convert(5'd0, 2'd2, 70);
    apb(1'b1, sac_pkg::OFS_CTRL, 32'h4);
    convert(5'd0, 2'd0, 30);
    sr_q.push_back(last);
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (120) @(posedge clock_i);
    conclude();
  end
endmodule : tb_top

bind sac_top sac_top_sva #(.RES_W(RES_W)) i_sva (.clock_i(clock_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
  .convert_start_n_i(convert_start_n_i), .cs_n_i(cs_n_i), .busy_o(busy_o), .data_o(data_o),
  .data_oe_o(data_oe_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .sclk_o(sclk_o),
  .sclk_oe_o(sclk_oe_o), .serial_data_out_oe_o(serial_data_out_oe_o));
`default_nettype wire
